// ---- rtl/ocds_top.sv ----
// ocds_top: debug entry/exit, probe pins, flash lock, APB registers
// assumes: cpu events on mclk, probe pins asynchronous
// Functional notes
// - status mirror is read-only, writes refused with slave error
// - flag accesses to core-reserved address range
// - four instruction-address breakpoints
// - single step breaks after each instruction
// - low serial pin forces a break
// - software break instruction breaks
// - break enters debug, peripherals per flag
// - leave debug on cancel or return
// - mask interrupts and NMI in debug
// - 64-byte work area, base readable
// - probe clock output, low at reset
// - serial pin bidirectional, input at reset
// - status output reports debug, low initially
// - pins debug by default, port selectable
// - locked flash reads return undefined data
// - locked flash programming raises error
// - correct key unlocks until next reset
// - level in bits 7:5, 15:8 zero
// - flags in bits 4:0, reset zero
// - base in bits 23:0, 31:24 zero
`timescale 1ns/1ps
`default_nettype none
module ocds_top #(
   parameter int NUM_PERIPH = 8,
   parameter logic [23:0] WORK_BASE = 24'h000FC0,
   parameter logic [31:0] UNLOCK_KEY = 32'h5A5A_A5A5 // arbitrary value
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // apb slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu side
   input wire ocds_pkg::ocds_cpu_s cpu_evt,
   input wire logic [7:0] psw_in,
   input wire logic [23:0] app_addr,
   input wire logic app_access,
   output logic core_io_hit,
   output logic debug_irq,
   output logic debug_mode,
   output logic irq_mask,
   output logic nmi_mask,
   // peripheral clock gating
   input wire logic [NUM_PERIPH-1:0] run_in_debug,
   output logic [NUM_PERIPH-1:0] periph_run,
   // probe command side
   input wire logic probe_cancel,
   input wire logic probe_flash_rd,
   input wire logic probe_prog_req,
   input wire logic [15:0] flash_rdata,
   output logic [15:0] probe_rdata,
   output logic probe_rvalid,
   output logic prog_go,
   output logic prog_err,
   // debug pins
   output logic probe_clock_out,
   input wire logic probe_serial_io_i,
   output logic probe_serial_io_o,
   output logic probe_serial_io_oe,
   output logic probe_status_out,
   output logic pins_to_port
);
   import ocds_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   ocds_mode_e mode_ff, nxt_mode;
   logic [31:0] ctrl_ff; // control register
   logic [3:0] cause_ff; // sticky entry causes
   logic lock_ff; // flash lock
   logic [24:0] bp_ff [NUM_BP]; // enable + address per slot
   logic [1:0] sio_sync_ff; // pin synchroniser
   logic [7:0] tx_ff; // shift register
   logic [3:0] tx_cnt_ff; // bits left to send
   logic [7:0] div_ff; // probe clock divider
   logic pclk_ff; // probe clock level
   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic irq_ff;
   logic io_hit_ff;
   logic [15:0] rdata_ff;
   logic rvalid_ff;
   logic prog_go_ff;
   logic prog_err_ff;
   logic [NUM_PERIPH-1:0] prun_ff;
   logic sio_oe_ff;
   logic [1:0] oe_hist_ff; // drive history of the serial pin

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire acc_done = psel & penable & pready_ff; // transfer completes
   wire wr_go = acc_done & pwrite;
   wire sel_status = (paddr == OFS_STATUS);
   wire sel_wbase = (paddr == OFS_WBASE);
   wire sel_ctrl = (paddr == OFS_CTRL);
   wire sel_dstat = (paddr == OFS_DSTAT);
   wire sel_key = (paddr == OFS_KEY);
   wire sel_tx = (paddr == OFS_TX);
   wire sel_bp = (paddr[7:4] == OFS_BP0[7:4]) && (paddr[1:0] == 2'b00);
   wire [1:0] bp_idx = paddr[3:2];
   wire ro_sel = sel_status | sel_wbase | sel_dstat;
   wire any_sel = ro_sel | sel_ctrl | sel_key | sel_tx | sel_bp;
   // writes to read-only words and unmapped words are refused
   wire bad_acc = ~any_sel | (pwrite & ro_sel);
   wire [31:0] status_word = {24'h000000, psw_in};
   wire [31:0] wbase_word = {8'h00, WORK_BASE};
   wire [31:0] dstat_word = {26'h0, lock_ff, cause_ff, mode_ff};
   wire [31:0] bp_word = {7'h00, bp_ff[bp_idx]};
   wire [31:0] rd_mux = sel_status ? status_word :
                        sel_wbase ? wbase_word :
                        sel_ctrl ? ctrl_ff :
                        sel_dstat ? dstat_word :
                        sel_bp ? bp_word : 32'h0000_0000;

   // ----------------------------------------
   // debug event sources
   // ----------------------------------------
   logic [NUM_BP-1:0] bp_match;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
         // enabled slot equal to the next fetch address
         assign bp_match[gi] = bp_ff[gi][BP_EN] &&
                               (bp_ff[gi][23:0] == cpu_evt.fetch_addr);
      end
   endgenerate
   wire pins_dbg = ~ctrl_ff[CTRL_GPIO];
   wire ev_bp = cpu_evt.fetch_valid & (|bp_match);
   wire ev_step = cpu_evt.instr_done & ctrl_ff[CTRL_STEP];
   // low level on the released data pin is a break request; the two cycles
   // after release are masked, the synchroniser still holds driven bits then
   wire ev_force = pins_dbg & ~sio_oe_ff & ~(|oe_hist_ff) & ~sio_sync_ff[1];
   wire ev_brk = cpu_evt.brk_exec;
   wire [3:0] ev_vec = {ev_brk, ev_force, ev_step, ev_bp};
   wire enter = (mode_ff == ST_RUN) & (|ev_vec);
   wire cancel_wr = wr_go & sel_ctrl & pwdata[CTRL_CANCEL];
   wire leave = (mode_ff == ST_DEBUG) &
                (probe_cancel | cancel_wr | cpu_evt.retd_exec);

   // ----------------------------------------
   // mode next state
   // ----------------------------------------
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         ST_RUN: begin
            if (enter) begin
               nxt_mode = ST_DEBUG;
            end
         end
         ST_DEBUG: begin
            if (leave) begin
               nxt_mode = ST_RUN;
            end
         end
         default: begin
            nxt_mode = ST_RUN;
         end
      endcase
   end

   // ----------------------------------------
   // mode register and debug outputs
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         mode_ff <= ST_RUN;
         irq_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         irq_ff <= enter; // one-cycle debug interrupt
      end
   end

   // sticky causes: set on entry, new causes replace at next entry
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cause_ff <= 4'h0;
      end else if (enter) begin
         cause_ff <= ev_vec;
      end
   end

   // peripherals run outside debug or when their flag allows it
   generate
      for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_per
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               prun_ff[gi] <= 1'b1;
            end else begin
               prun_ff[gi] <= (nxt_mode == ST_RUN) | run_in_debug[gi];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // control and breakpoint registers
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl_ff <= CTRL_RST;
      end else if (wr_go && sel_ctrl) begin
         // cancel bit is a strobe and is not stored
         ctrl_ff <= {25'h0, 1'b0, pwdata[CTRL_GPIO:CTRL_STEP], 4'h0};
      end
   end

   generate
      for (gi = 0; gi < NUM_BP; gi++) begin : g_bpreg
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               bp_ff[gi] <= 25'h0;
            end else if (wr_go && sel_bp && (bp_idx == 2'(gi))) begin
               bp_ff[gi] <= pwdata[24:0];
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // flash lock
   // ----------------------------------------
   // locked at every reset, opened only by the exact key
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         lock_ff <= 1'b1;
      end else if (wr_go && sel_key && (pwdata == UNLOCK_KEY)) begin
         lock_ff <= 1'b0;
      end
   end

   // probe flash access gate
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'b0;
         prog_go_ff <= 1'b0;
         prog_err_ff <= 1'b0;
      end else begin
         rvalid_ff <= probe_flash_rd;
         if (probe_flash_rd) begin
            rdata_ff <= lock_ff ? UNDEF_DATA : flash_rdata;
         end
         prog_go_ff <= probe_prog_req & ~lock_ff;
         prog_err_ff <= probe_prog_req & lock_ff;
      end
   end

   // ----------------------------------------
   // reserved address watch
   // ----------------------------------------
   wire io_range = (app_addr >= CORE_IO_LO) && (app_addr <= CORE_IO_HI);
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         io_hit_ff <= 1'b0;
      end else begin
         io_hit_ff <= app_access & io_range;
      end
   end

   // ----------------------------------------
   // probe link
   // ----------------------------------------
   // two-stage synchroniser on the serial pin
   // and a record of the last two drive cycles
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sio_sync_ff <= 2'b11;
         oe_hist_ff <= 2'b00;
      end else begin
         sio_sync_ff <= {sio_sync_ff[0], probe_serial_io_i};
         oe_hist_ff <= {oe_hist_ff[0], sio_oe_ff};
      end
   end

   wire tx_busy = (tx_cnt_ff != 4'h0);
   wire div_end = (div_ff == 8'(HALF_CYC - 1));
   wire fall = div_end & pclk_ff; // probe clock about to fall
   wire tx_load = wr_go & sel_tx & ~tx_busy & pins_dbg;

   // clock runs only while a byte is shifted out
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         div_ff <= 8'h00;
         pclk_ff <= 1'b0;
      end else if (!tx_busy) begin
         div_ff <= 8'h00;
         pclk_ff <= 1'b0;
      end else if (div_end) begin
         div_ff <= 8'h00;
         pclk_ff <= ~pclk_ff;
      end else begin
         div_ff <= div_ff + 8'h01;
      end
   end

   // msb first, next bit presented on each falling clock
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         tx_ff <= 8'h00;
         tx_cnt_ff <= 4'h0;
         sio_oe_ff <= 1'b0;
      end else if (tx_load) begin
         tx_ff <= pwdata[7:0];
         tx_cnt_ff <= 4'h8;
         sio_oe_ff <= 1'b1;
      end else if (fall) begin
         tx_ff <= {tx_ff[6:0], 1'b0};
         tx_cnt_ff <= tx_cnt_ff - 4'h1;
         sio_oe_ff <= (tx_cnt_ff != 4'h1);
      end
   end

   // ----------------------------------------
   // apb response
   // ----------------------------------------
   // one wait state: pready rises in the second access cycle
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= psel & penable & ~pready_ff;
         pslverr_ff <= psel & penable & ~pready_ff & bad_acc;
         if (psel && penable && !pready_ff && !pwrite) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign debug_irq = irq_ff;
   assign debug_mode = mode_ff;
   assign irq_mask = mode_ff;
   assign nmi_mask = mode_ff;
   assign periph_run = prun_ff;
   assign core_io_hit = io_hit_ff;
   assign probe_rdata = rdata_ff;
   assign probe_rvalid = rvalid_ff;
   assign prog_go = prog_go_ff;
   assign prog_err = prog_err_ff;
   assign probe_clock_out = pclk_ff;
   assign probe_serial_io_o = tx_ff[7];
   assign probe_serial_io_oe = sio_oe_ff;
   assign probe_status_out = mode_ff;
   assign pins_to_port = ctrl_ff[CTRL_GPIO];
endmodule : ocds_top
`default_nettype wire

// ---- rtl/ocds_pkg.sv ----
// ocds_pkg: constants and types of the on-chip debug support block
// assumes: APB with 32-bit data, 100 MHz mclk
package ocds_pkg;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_STATUS = 8'h00; // cpu_status_mirror
   localparam logic [7:0] OFS_WBASE = 8'h04; // debug_work_base
   localparam logic [7:0] OFS_CTRL = 8'h08; // debug control
   localparam logic [7:0] OFS_DSTAT = 8'h0C; // debug status
   localparam logic [7:0] OFS_BP0 = 8'h10; // breakpoint slot 0, +4 per slot
   localparam logic [7:0] OFS_KEY = 8'h20; // flash unlock key
   localparam logic [7:0] OFS_TX = 8'h24; // serial transmit byte
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_STEP = 4; // single-step enable
   localparam int CTRL_GPIO = 5; // pins given to port use
   localparam int CTRL_CANCEL = 6; // write 1: cancel debug mode
   localparam int BP_EN = 24; // slot enable bit in slot register
   localparam int NUM_BP = 4; // breakpoint slots
   // ----------------------------------------
   // reset values and ranges
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [23:0] CORE_IO_LO = 24'hFFFC00;
   localparam logic [23:0] CORE_IO_HI = 24'hFFFFFF;
   localparam int WORK_BYTES = 64; // debug work area size
   localparam logic [15:0] UNDEF_DATA = 16'hFFFF; // flash read under lock
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int MCLK_MHZ = 100;
   localparam int LINK_NS = 125; // probe clock period
   localparam int HALF_CYC = (LINK_NS * MCLK_MHZ) / 2000; // rounds down
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [0:0] {
      ST_RUN = 1'b0,
      ST_DEBUG = 1'b1
   } ocds_mode_e;
   typedef struct packed {
      logic fetch_valid; // next instruction about to execute
      logic [23:0] fetch_addr; // its address
      logic instr_done; // one instruction completed
      logic brk_exec; // software break executed
      logic retd_exec; // debug return executed
   } ocds_cpu_s;
endpackage : ocds_pkg

// ---- tb/ocds_assertions.sv ----
// ocds_assertions: port-level checks of the on-chip debug support block
// assumes: bound into ocds_top, single clock domain on mclk
`timescale 1ns/1ps
`default_nettype none
module ocds_assertions (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // cpu side
   input wire ocds_pkg::ocds_cpu_s cpu_evt,
   input wire logic [23:0] app_addr,
   input wire logic app_access,
   input wire logic core_io_hit,
   input wire logic debug_irq,
   input wire logic debug_mode,
   input wire logic irq_mask,
   input wire logic nmi_mask,
   // probe side
   input wire logic probe_cancel,
   input wire logic probe_flash_rd,
   input wire logic probe_rvalid,
   input wire logic probe_prog_req,
   input wire logic prog_go,
   input wire logic prog_err,
   // debug pins
   input wire logic probe_clock_out,
   input wire logic probe_serial_io_i,
   input wire logic probe_serial_io_oe,
   input wire logic probe_status_out,
   input wire logic pins_to_port
);
   import ocds_pkg::*;
   // ----------------------------------------
   // clocking and reset for all checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // debug entry and exit
   // ----------------------------------------
   chk_brk_entry: assert property (!debug_mode && cpu_evt.brk_exec |=> debug_mode && debug_irq)
      else $error("software break did not enter debug");
   chk_irq_pulse: assert property ($rose(debug_mode) |-> debug_irq ##1 !debug_irq)
      else $error("debug interrupt not a single pulse at entry");
   chk_force_brk: assert property ($fell(probe_serial_io_i) && !probe_serial_io_oe && !pins_to_port
      && !debug_mode |-> ##[1:5] debug_mode)
      else $error("low serial pin did not force a break");
   chk_cancel_exit: assert property (debug_mode && probe_cancel |=> !debug_mode)
      else $error("cancel did not leave debug");
   chk_return_exit: assert property (debug_mode && cpu_evt.retd_exec |=> !debug_mode)
      else $error("debug return did not leave debug");
   chk_int_masked: assert property (debug_mode |-> irq_mask && nmi_mask)
      else $error("interrupts open in debug");
   chk_status_pin: assert property (1'b1 |-> probe_status_out == debug_mode)
      else $error("status pin differs from debug mode");
   // ----------------------------------------
   // pins, flash and address checks
   // ----------------------------------------
   chk_clock_idle: assert property (!probe_serial_io_oe |-> !probe_clock_out)
      else $error("probe clock high while idle");
   chk_flash_reply: assert property (probe_flash_rd |=> probe_rvalid)
      else $error("flash read not answered");
   chk_prog_reply: assert property (probe_prog_req |=> prog_go != prog_err)
      else $error("program request not answered once");
   chk_core_io: assert property (app_access |=> core_io_hit == ($past(app_addr) >= CORE_IO_LO))
      else $error("reserved range flag wrong");
   // main scenarios seen
   cover property (debug_mode && probe_cancel);
   cover property ($fell(probe_serial_io_oe));
   cover property (prog_go);
endmodule : ocds_assertions
bind ocds_top ocds_assertions ocds_assertions_inst (
   .mclk(mclk), .rst_b(rst_b), .cpu_evt(cpu_evt), .app_addr(app_addr), .app_access(app_access),
   .core_io_hit(core_io_hit), .debug_irq(debug_irq), .debug_mode(debug_mode), .irq_mask(irq_mask),
   .nmi_mask(nmi_mask), .probe_cancel(probe_cancel), .probe_flash_rd(probe_flash_rd),
   .probe_rvalid(probe_rvalid), .probe_prog_req(probe_prog_req), .prog_go(prog_go), .prog_err(prog_err),
   .probe_clock_out(probe_clock_out), .probe_serial_io_i(probe_serial_io_i),
   .probe_serial_io_oe(probe_serial_io_oe), .probe_status_out(probe_status_out), .pins_to_port(pins_to_port)
);
`default_nettype wire

// ---- tb/ocds_probe_model.sv ----
// ocds_probe_model: external debug probe as seen on the clock and serial pins
// assumes: device makes the clock, probe listens or requests a break
`timescale 1ns/1ps
`default_nettype none
module ocds_probe_model (
   // device pins
   input wire logic clk_out,
   input wire logic sio_o,
   input wire logic sio_oe,
   // bench control
   input wire logic brk_req,
   // resolved pin level and received byte
   output logic sio_i,
   output logic [7:0] rx_byte
);
   // device drive wins, else probe pulls low for a break, else pull-up
   assign sio_i = sio_oe ? sio_o : !brk_req;
   // probe only samples the clock pin, never drives it
   always @(posedge clk_out) begin
      if (sio_oe) begin
         rx_byte <= {rx_byte[6:0], sio_o};
      end
   end
endmodule : ocds_probe_model
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: directed scenarios for the on-chip debug support block
// assumes: ocds_top with default parameters, probe model on the pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ocds_pkg::*;
   // ----------------------------------------
   // stimulus and observation signals
   // ----------------------------------------
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, app_access = 1'b0, brk_req = 1'b0;
   logic probe_cancel = 1'b0, probe_flash_rd = 1'b0, probe_prog_req = 1'b0;
   logic [31:0] pwdata = 32'h0;
   ocds_cpu_s cpu_evt = '0;
   logic [7:0] psw_in = 8'h00;
   logic [23:0] app_addr = 24'h0;
   logic [15:0] flash_rdata = 16'h1234;
   logic [31:0] prdata;
   logic [15:0] probe_rdata;
   logic [7:0] periph_run, rx_byte;
   logic pready, pslverr, core_io_hit, debug_irq, debug_mode, irq_mask, nmi_mask, probe_rvalid;
   logic prog_go, prog_err, probe_clock_out, sio_i, sio_o, sio_oe, probe_status_out, pins_to_port;
   int error_cnt = 0;
   int cmp_count = 0;
   always #5 mclk = ~mclk;
   ocds_top ocds_top_inst (.mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_evt(cpu_evt),
      .psw_in(psw_in), .app_addr(app_addr), .app_access(app_access), .core_io_hit(core_io_hit),
      .debug_irq(debug_irq), .debug_mode(debug_mode), .irq_mask(irq_mask), .nmi_mask(nmi_mask),
      .run_in_debug(8'h0F), .periph_run(periph_run), .probe_cancel(probe_cancel), .probe_flash_rd(probe_flash_rd),
      .probe_prog_req(probe_prog_req), .flash_rdata(flash_rdata), .probe_rdata(probe_rdata),
      .probe_rvalid(probe_rvalid), .prog_go(prog_go), .prog_err(prog_err), .probe_clock_out(probe_clock_out),
      .probe_serial_io_i(sio_i), .probe_serial_io_o(sio_o), .probe_serial_io_oe(sio_oe),
      .probe_status_out(probe_status_out), .pins_to_port(pins_to_port));
   ocds_probe_model ocds_probe_model_inst (.clk_out(probe_clock_out), .sio_o(sio_o), .sio_oe(sio_oe),
      .brk_req(brk_req), .sio_i(sio_i), .rx_byte(rx_byte));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // apb transfer; exp bit 32 is the error flag, data compared on good reads only
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] exp);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      // only the watchdog ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge mclk);
      end
      chk((wr | exp[32]) ? {pslverr, 32'h0} : {pslverr, prdata}, exp);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : acc
   // one-cycle cpu event pulse
   task automatic ev(input ocds_cpu_s e);
      @(posedge mclk);
      cpu_evt <= e;
      @(posedge mclk);
      cpu_evt <= '0;
   endtask : ev
   // bounded wait for a debug mode level
   task automatic wait_dbg(input logic exp);
      int n;
      n = 0;
      while (debug_mode !== exp && n < 12) begin
         n++;
         @(posedge mclk);
      end
   endtask : wait_dbg
   task automatic cancel();
      @(posedge mclk);
      probe_cancel <= 1'b1;
      @(posedge mclk);
      probe_cancel <= 1'b0;
      wait_dbg(1'b0);
   endtask : cancel
   // flash read and program request together, answer one cycle later
   task automatic flash(input logic locked);
      @(posedge mclk);
      probe_flash_rd <= 1'b1;
      probe_prog_req <= 1'b1;
      @(posedge mclk);
      probe_flash_rd <= 1'b0;
      probe_prog_req <= 1'b0;
      @(posedge mclk);
      chk({probe_rvalid, probe_rdata}, {1'b1, locked ? UNDEF_DATA : flash_rdata});
      chk({prog_go, prog_err}, {!locked, locked});
   endtask : flash
   task automatic io(input logic [23:0] a, input logic hit);
      @(posedge mclk);
      app_access <= 1'b1;
      app_addr <= a;
      @(posedge mclk);
      app_access <= 1'b0;
      @(posedge mclk);
      chk(core_io_hit, hit);
   endtask : io
   task automatic do_reset();
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
   endtask : do_reset
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      psw_in <= 8'hB5;
      acc(1'b0, OFS_STATUS, 32'h0, {1'b0, 32'h0000_00B5});
      acc(1'b1, OFS_STATUS, 32'hFFFF_FFFF, {1'b1, 32'h0});
      acc(1'b0, OFS_STATUS, 32'h0, {1'b0, 32'h0000_00B5});
      acc(1'b0, OFS_WBASE, 32'h0, {9'h0, 24'h000FC0});
      acc(1'b1, OFS_WBASE, 32'h0, {1'b1, 32'h0});
      acc(1'b0, 8'h3C, 32'h0, {1'b1, 32'h0});
      io(24'hFFFBFF, 1'b0); io(24'hFFFC00, 1'b1); io(24'hFFFFFF, 1'b1);
      $display("test regs done");
   endtask : t_regs
   task automatic t_events();
      ev({25'h0, 3'b010});
      wait_dbg(1'b1);
      chk({debug_mode, irq_mask, nmi_mask, probe_status_out, periph_run}, {4'hF, 8'h0F});
      acc(1'b0, OFS_DSTAT, 32'h0, {1'b0, 32'h0000_0031});
      ev({25'h0, 3'b001});
      wait_dbg(1'b0);
      chk({debug_mode, periph_run}, 9'h0FF);
      for (int i = 0; i < NUM_BP; i++) begin
         acc(1'b1, OFS_BP0 + 8'(4 * i), 32'h0100_2000 + 32'(i), 33'h0);
         ev({1'b1, 24'h002000 + 24'(i), 3'b000});
         wait_dbg(1'b1);
         chk(debug_mode, 1'b1);
         cancel();
         chk(debug_mode, 1'b0);
      end
      acc(1'b1, OFS_BP0, 32'h0000_2000, 33'h0);
      acc(1'b0, OFS_BP0, 32'h0, {1'b0, 32'h0000_2000});
      ev({1'b1, 24'h002000, 3'b000});
      wait_dbg(1'b1);
      chk(debug_mode, 1'b0);
      acc(1'b1, OFS_CTRL, 32'h10, 33'h0);
      acc(1'b0, OFS_CTRL, 32'h0, {1'b0, 32'h0000_0010});
      ev({25'h0, 3'b100});
      wait_dbg(1'b1);
      chk(debug_mode, 1'b1);
      acc(1'b1, OFS_CTRL, 32'h40, 33'h0);
      wait_dbg(1'b0);
      chk(debug_mode, 1'b0);
      $display("test events done");
   endtask : t_events
   task automatic t_pins();
      brk_req <= 1'b1;
      wait_dbg(1'b1);
      chk(debug_mode, 1'b1);
      brk_req <= 1'b0;
      repeat (4) @(posedge mclk);
      acc(1'b1, OFS_TX, 32'hA5, 33'h0);
      repeat (110) @(posedge mclk);
      chk({rx_byte, sio_oe, probe_clock_out}, {8'hA5, 2'b00});
      cancel();
      acc(1'b1, OFS_CTRL, 32'h20, 33'h0);
      brk_req <= 1'b1;
      wait_dbg(1'b1);
      chk({pins_to_port, debug_mode}, 2'b10);
      brk_req <= 1'b0;
      acc(1'b1, OFS_CTRL, 32'h0, 33'h0);
      $display("test pins done");
   endtask : t_pins
   task automatic t_flash();
      flash(1'b1);
      acc(1'b1, OFS_KEY, 32'h5A5A_A5A4, 33'h0);
      flash(1'b1);
      acc(1'b1, OFS_KEY, 32'h5A5A_A5A5, 33'h0);
      flash(1'b0);
      do_reset();
      chk({debug_mode, pins_to_port, sio_oe, periph_run}, 11'h0FF);
      flash(1'b1);
      $display("test flash done");
   endtask : t_flash
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      chk({probe_clock_out, sio_oe, probe_status_out, debug_mode, pins_to_port, periph_run}, 13'h0FF);
      t_regs();
      t_events();
      t_pins();
      t_flash();
      end_of_test();
   end
   initial begin
      #100us;
      error_cnt++;
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
